/* File: common/cxp_map.svh */
`ifndef CXP_MAP_SVH
`define CXP_MAP_SVH

// register addresses on the serial control port
`define CXP_ADDR_W          15
`define CXP_OFS_CHAN_PWR    15'h0002
`define CXP_OFS_MAKER_LO    15'h000C
`define CXP_OFS_MAKER_HI    15'h000D
`define CXP_OFS_COMMIT      15'h000F
`define CXP_OFS_PIN_GATE    15'h003F
`define CXP_OFS_PIN_FUNC    15'h0040
`define CXP_OFS_PHASE_MODE  15'h0300

// field positions
`define CXP_COMMIT_BIT      0
`define CXP_PIN_GATE_BIT    7
`define CXP_PIN_FUNC_HI     7
`define CXP_PIN_FUNC_LO     6
`define CXP_PHASE_MODE_BIT  7
`define CXP_CHAN_PWR_HI     1
`define CXP_CHAN_PWR_LO     0

// pin function codes
`define CXP_FUNC_PDWN       2'h0
`define CXP_FUNC_STBY       2'h1
`define CXP_FUNC_OFF        2'h2

// reset values
`define CXP_RST_BYTE        8'h00
`define CXP_RST_FUNC        2'h0
`define CXP_RST_CHAN_PWR    2'h0

`endif

/* File: common/cxp_pkg.sv */
`default_nettype none
package cxp_pkg;
  typedef enum logic [0:0] {
    XFER_IDLE,
    XFER_COPY
  } cxp_xfer_state_t;
endpackage
`default_nettype wire

/* File: verilog/cxp_chip_ctrl.sv */
// Behaviour
// - transfer bit 0 self-clears once the pending transfer has completed
// - transfer loads mixer phase increment and offset only when phase update mode set
// - all mixer phase settings update together in one cycle
// - transfer also copies staged filter coefficients into working storage
// - staged values have no effect until the transfer copies them
// - pin-disable bit resets to zero; one makes the sleep pin ignored
// - enabled pin action follows global pin function field bits 7:6 of 0x0040
// - function 00 power-down, 01 standby, 10 pin ignored
// - honoured pin assertion overrides per-channel power mode bits
`timescale 1ns/1ps
`default_nettype none
`include "cxp_map.svh"

module cxp_chip_ctrl #(
  parameter int          PHASE_W    = 48,
  parameter int          COEFF_W    = 192,
  parameter logic [15:0] MAKER_CODE = 16'h00A5  // arbitrary value
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // register access from the serial control port
  input  wire logic [`CXP_ADDR_W-1:0] reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  // staged (master) values
  input  wire logic [PHASE_W-1:0]     staged_phase_inc,
  input  wire logic [PHASE_W-1:0]     staged_phase_ofs,
  input  wire logic [COEFF_W-1:0]     staged_coeff,
  // working (slave) values
  output logic      [PHASE_W-1:0]     work_phase_inc,
  output logic      [PHASE_W-1:0]     work_phase_ofs,
  output logic      [COEFF_W-1:0]     work_coeff,
  output logic                        commit_done,
  // sleep pin and power control
  input  wire logic                   sleep_request_pin,
  output logic                        power_down_req,
  output logic                        standby_req,
  output logic                        pin_override,
  output logic      [1:0]             chan_power_mode
);

  // refuse widths the copy logic cannot serve
  if (PHASE_W < 1 || COEFF_W < 1) begin : g_bad_width
    $error("cxp_chip_ctrl: widths must be positive");
  end

  cxp_pkg::cxp_xfer_state_t state_reg, state_next;
  logic                     commit_reg;
  logic                     pin_gate_reg;
  logic [1:0]               pin_func_reg;
  logic                     phase_mode_reg;
  logic [1:0]               chan_pwr_reg;
  logic                     pin_meta_reg;
  logic                     pin_sync_reg;
  logic [7:0]               rdata_next;

  // address decode
  wire wr_commit = reg_wr && reg_addr == `CXP_OFS_COMMIT;
  wire wr_gate   = reg_wr && reg_addr == `CXP_OFS_PIN_GATE;
  wire wr_func   = reg_wr && reg_addr == `CXP_OFS_PIN_FUNC;
  wire wr_phase  = reg_wr && reg_addr == `CXP_OFS_PHASE_MODE;
  wire wr_chan   = reg_wr && reg_addr == `CXP_OFS_CHAN_PWR;
  wire set_commit = wr_commit && reg_wdata[`CXP_COMMIT_BIT];
  wire copying    = state_reg == cxp_pkg::XFER_COPY;

  // transfer sequence
  always_comb begin
    case (state_reg)
      cxp_pkg::XFER_IDLE: state_next = commit_reg ? cxp_pkg::XFER_COPY : cxp_pkg::XFER_IDLE;
      cxp_pkg::XFER_COPY: state_next = cxp_pkg::XFER_IDLE;
      default:            state_next = cxp_pkg::XFER_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg  <= cxp_pkg::XFER_IDLE;
      commit_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (set_commit) begin
        commit_reg <= 1'b1;
      end else if (copying) begin
        commit_reg <= 1'b0;
      end
    end
  end

  assign commit_done = copying;

  // working copies, loaded only by the transfer
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      work_phase_inc <= '0;
      work_phase_ofs <= '0;
      work_coeff     <= '0;
    end else if (copying) begin
      work_coeff <= staged_coeff;
      if (phase_mode_reg) begin
        work_phase_inc <= staged_phase_inc;
        work_phase_ofs <= staged_phase_ofs;
      end
    end
  end

  // control registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_gate_reg   <= 1'b0;
      pin_func_reg   <= `CXP_RST_FUNC;
      phase_mode_reg <= 1'b0;
      chan_pwr_reg   <= `CXP_RST_CHAN_PWR;
    end else begin
      if (wr_gate) begin
        pin_gate_reg <= reg_wdata[`CXP_PIN_GATE_BIT];
      end
      if (wr_func) begin
        pin_func_reg <= reg_wdata[`CXP_PIN_FUNC_HI:`CXP_PIN_FUNC_LO];
      end
      if (wr_phase) begin
        phase_mode_reg <= reg_wdata[`CXP_PHASE_MODE_BIT];
      end
      if (wr_chan) begin
        chan_pwr_reg <= reg_wdata[`CXP_CHAN_PWR_HI:`CXP_CHAN_PWR_LO];
      end
    end
  end

  // read data
  always_comb begin
    case (reg_addr)
      `CXP_OFS_MAKER_LO:   rdata_next = MAKER_CODE[7:0];
      `CXP_OFS_MAKER_HI:   rdata_next = MAKER_CODE[15:8];
      `CXP_OFS_COMMIT:     rdata_next = {7'h00, commit_reg};
      `CXP_OFS_PIN_GATE:   rdata_next = {pin_gate_reg, 7'h00};
      `CXP_OFS_PIN_FUNC:   rdata_next = {pin_func_reg, 6'h00};
      `CXP_OFS_PHASE_MODE: rdata_next = {phase_mode_reg, 7'h00};
      `CXP_OFS_CHAN_PWR:   rdata_next = {6'h00, chan_pwr_reg};
      default:             rdata_next = `CXP_RST_BYTE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= `CXP_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // sleep pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= sleep_request_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // pin decode
  wire func_pd  = pin_func_reg == `CXP_FUNC_PDWN;
  wire func_sb  = pin_func_reg == `CXP_FUNC_STBY;
  wire pin_live = !pin_gate_reg && (func_pd || func_sb);
  wire pin_hit  = pin_live && pin_sync_reg;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      power_down_req  <= 1'b0;
      standby_req     <= 1'b0;
      pin_override    <= 1'b0;
      chan_power_mode <= `CXP_RST_CHAN_PWR;
    end else begin
      power_down_req  <= pin_hit && func_pd;
      standby_req     <= pin_hit && func_sb;
      pin_override    <= pin_hit;
      chan_power_mode <= pin_hit ? chan_power_mode : chan_pwr_reg;
    end
  end

  // checks
  chk_commit_clears: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    commit_reg && !copying |=> copying ##1 (!commit_reg || $past(set_commit)))
    else $error("commit bit did not clear after transfer");

  chk_commit_sets: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    set_commit |=> commit_reg)
    else $error("commit write did not set bit");

  chk_phase_gated: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    copying && !phase_mode_reg |=> $stable(work_phase_inc) && $stable(work_phase_ofs))
    else $error("phase loaded with update mode off");

  chk_phase_together: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    copying && phase_mode_reg |=> work_phase_inc == $past(staged_phase_inc)
      && work_phase_ofs == $past(staged_phase_ofs))
    else $error("phase settings not loaded together");

  chk_coeff_load: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    copying |=> work_coeff == $past(staged_coeff))
    else $error("coefficients not transferred");

  chk_no_early: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !copying |=> $stable(work_coeff))
    else $error("working value changed without transfer");

  chk_pin_gate: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    pin_gate_reg && $past(pin_gate_reg) |-> !pin_override)
    else $error("gated pin still acted");

  chk_pin_func: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    pin_sync_reg && !pin_gate_reg && pin_func_reg == `CXP_FUNC_STBY
      |=> standby_req && !power_down_req)
    else $error("pin function not followed");

  chk_pin_off: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    pin_func_reg == `CXP_FUNC_OFF |=> !power_down_req && !standby_req)
    else $error("disabled pin function acted");

  chk_pin_prio: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    pin_override && $past(pin_hit) && pin_hit |=> $stable(chan_power_mode))
    else $error("channel mode changed under pin override");

endmodule // cxp_chip_ctrl

`default_nettype wire

/* File: testbench/cxp_chip_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cxp_map.svh"

module cxp_chip_ctrl_bench;
  localparam logic [15:0] MK = 16'h3C5A;  // arbitrary value
  logic                   ref_clk, rstn, reg_wr, reg_rd, sleep_request_pin;
  logic [`CXP_ADDR_W-1:0] reg_addr;
  logic [7:0]             reg_wdata, reg_rdata, s_inc, s_ofs, s_cf, w_inc, w_ofs, w_cf, rv;
  logic                   done, pdn, stb, ovr;
  logic [1:0]             cpm;
  int                     err_total, num_checks;

  cxp_chip_ctrl #(.PHASE_W(8), .COEFF_W(8), .MAKER_CODE(MK)) cxp_chip_ctrl_i (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .staged_phase_inc(s_inc), .staged_phase_ofs(s_ofs),
    .staged_coeff(s_cf), .work_phase_inc(w_inc), .work_phase_ofs(w_ofs), .work_coeff(w_cf),
    .commit_done(done), .sleep_request_pin(sleep_request_pin), .power_down_req(pdn),
    .standby_req(stb), .pin_override(ovr), .chan_power_mode(cpm));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [14:0] a, input logic [7:0] e, input string n);
    reg_addr = a; reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
    chk(n, e, reg_rdata);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic reset_values;
    wr(`CXP_OFS_MAKER_LO, 8'hFF);
    rd(`CXP_OFS_MAKER_LO, MK[7:0], "maker_lo");
    rd(`CXP_OFS_MAKER_HI, MK[15:8], "maker_hi");
    rd(`CXP_OFS_COMMIT, 8'h00, "commit_rst");
    rd(`CXP_OFS_PIN_GATE, 8'h00, "gate_rst");
    rd(15'h0001, 8'h00, "unmapped");
  endtask

  task automatic commit(input logic [7:0] mode, input logic [7:0] pi, input logic [7:0] po,
                        input logic [7:0] pc);
    int i;
    wr(`CXP_OFS_PHASE_MODE, mode);
    s_inc = s_inc + 8'h11; s_ofs = s_ofs + 8'h22; s_cf = s_cf + 8'h33;
    @(negedge ref_clk);
    chk("coeff_early", pc, w_cf);
    chk("inc_early", pi, w_inc);
    chk("ofs_early", po, w_ofs);
    reg_addr = `CXP_OFS_COMMIT; reg_wdata = 8'h01; reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    for (i = 0; i < 6 && done !== 1'b1; i++) @(negedge ref_clk);
    chk("done", 1'b1, done);
    @(negedge ref_clk);
    chk("coeff", s_cf, w_cf);
    chk("inc", mode[7] ? s_inc : pi, w_inc);
    chk("ofs", mode[7] ? s_ofs : po, w_ofs);
    chk("done_low", 1'b0, done);
    rd(`CXP_OFS_COMMIT, 8'h00, "commit_clr");
  endtask

  task automatic pin_case(input logic [7:0] gate, input logic [1:0] f);
    logic h;
    h = !gate[7] && f < 2'h2;
    wr(`CXP_OFS_PIN_GATE, gate);
    wr(`CXP_OFS_PIN_FUNC, {f, 6'h00});
    wr(`CXP_OFS_CHAN_PWR, 8'h03);
    sleep_request_pin = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("pdn", h && f == `CXP_FUNC_PDWN, pdn);
    chk("stb", h && f == `CXP_FUNC_STBY, stb);
    chk("ovr", h, ovr);
    wr(`CXP_OFS_CHAN_PWR, 8'h01);
    chk("cpm_hold", h ? 2'h3 : 2'h1, cpm);
    sleep_request_pin = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("ovr_off", 1'b0, ovr);
    chk("cpm_free", 2'h1, cpm);
  endtask

  initial begin
    #250000;
    err_total++;
    conclude();
  end

  initial begin
    rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
    sleep_request_pin = 1'b0; s_inc = 8'h00; s_ofs = 8'h11; s_cf = 8'h00;
    err_total = 0; num_checks = 0;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    reset_values();
    commit(8'h00, 8'h00, 8'h00, 8'h00);
    commit(8'h80, 8'h00, 8'h00, 8'h33);
    for (int f = 0; f < 4; f++) pin_case(8'h00, f[1:0]);
    pin_case(8'h80, `CXP_FUNC_PDWN);
    conclude();
  end
endmodule // cxp_chip_ctrl_bench

`default_nettype wire
